// File: logic/low_power_mode_arbiter.sv
// Low-power mode arbiter: picks the mode actually entered
module low_power_mode_arbiter
    import lpm_arbiter_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire lpm_arbiter_pkg::pmode_t req_mode,
    input  wire logic                   high_side_supervisor_enable,
    input  wire logic [lpm_arbiter_pkg::N_PERIPH-1:0] p_active,
    input  wire logic [lpm_arbiter_pkg::N_PERIPH-1:0] p_waiting,
    input  wire logic [lpm_arbiter_pkg::N_PERIPH*2-1:0] p_src,
    input  wire logic [lpm_arbiter_pkg::N_PERIPH-1:0] p_slow_unclocked,
    input  wire logic [lpm_arbiter_pkg::N_PERIPH*
                       lpm_arbiter_pkg::FREQ_W-1:0] p_ext_freq,
    input  wire logic                   dma_trigger,
    input  wire logic                   dma_done,
    input  wire logic                   crc_busy,
    input  wire logic                   hardware_multiplier_busy,
    input  wire logic                   cipher_busy,
    input  wire logic                   irq_pending,
    input  wire logic                   irq_return,
    output lpm_arbiter_pkg::pmode_t     cur_mode,
    output logic                        supply_supervisor,
    output logic                        core_supply_on,
    output logic                        periph_reset,
    output logic                        rtc_keep_alive
);
    import lpm_arbiter_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pmode_t mode;
        logic   dma_xfer;
        logic   in_isr;
        logic   supervisor;
    } state_t;

    state_t s_q;
    state_t s_d;

    pstate_t st [N_PERIPH];
    logic    need_high;
    logic    need_low;
    logic    need_unclk;
    logic    accel_busy;
    pmode_t  allowed;
    pmode_t  target;

    // ------------------------------------------------------------
    // Peripheral classification
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N_PERIPH; g++) begin : g_cls
            periph_classifier u_cls (
                .active                (p_active[g]),
                .waiting               (p_waiting[g]),
                .src                   (csrc_t'(p_src[g*2 +: 2])),
                .ext_freq_hz           (p_ext_freq[g*FREQ_W +: FREQ_W]),
                .ext_slow_is_unclocked (p_slow_unclocked[g]),
                .state                 (st[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Deepest supported mode, re-evaluated every cycle
    // ------------------------------------------------------------
    always_comb begin
        need_high  = 1'b0;
        need_low   = 1'b0;
        need_unclk = 1'b0;
        for (int i = 0; i < N_PERIPH; i++) begin
            if (st[i] == st_high_freq) need_high = 1'b1;   // [RULE_12]
            if (st[i] == st_low_freq)  need_low  = 1'b1;
            if (st[i] == st_unclocked) need_unclk = 1'b1;
        end
        if (need_high) begin
            allowed = cpu_off_mode_deep;                     // [RULE_03]
        end else if (need_low) begin
            allowed = standby_mode_b;                        // [RULE_03]
        end else if (need_unclk) begin
            allowed = clocks_off_mode;                       // [RULE_03]
        end else begin
            allowed = shutdown_mode;
        end
        // Shallower of request and allowed
        target = (req_mode < allowed) ? req_mode : allowed; // [RULE_03]
        accel_busy = crc_busy | hardware_multiplier_busy | cipher_busy;
    end

    // ------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (dma_trigger && s_q.mode != active_mode) begin
            s_d.dma_xfer = 1'b1;                             // [RULE_05]
        end else if (dma_done) begin
            s_d.dma_xfer = 1'b0;                             // [RULE_05]
        end
        if (irq_pending && s_q.mode != active_mode) begin
            s_d.in_isr = 1'b1;                               // [RULE_10]
        end else if (irq_return) begin
            s_d.in_isr = 1'b0;                               // [RULE_10]
        end
        if (target != active_mode && accel_busy) begin
            s_d.mode = active_mode;                          // [RULE_06]
        end else begin
            s_d.mode = target;                               // [RULE_12]
        end
        unique case (s_d.mode)
            standby_mode_a, standby_mode_b,
            clocks_off_mode, rtc_only_mode,
            shutdown_mode: s_d.supervisor = high_side_supervisor_enable; // [RULE_01]
            default:       s_d.supervisor = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{mode: active_mode, dma_xfer: 1'b0,
                     in_isr: 1'b0, supervisor: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic wake;
    logic deep_off;
    assign wake = s_q.dma_xfer | (s_q.in_isr &&
                  s_q.mode < rtc_only_mode);                 // [RULE_05] [RULE_10]
    assign deep_off = s_q.mode >= rtc_only_mode;             // [RULE_11]
    assign cur_mode          = wake && !deep_off ? active_mode : s_q.mode;
    assign supply_supervisor = s_q.supervisor;
    assign core_supply_on    = !deep_off;                    // [RULE_11]
    assign periph_reset      = deep_off;                     // [RULE_11]
    assign rtc_keep_alive    = s_q.mode != shutdown_mode;    // [RULE_11]
endmodule

// File: logic/lpm_arbiter_pkg.sv
// Package: mode codes, peripheral state codes and sizing constants
// Summary of operation
// (RULE_01) Supervisor on in deep modes only when enabled
// (RULE_02) Peripheral states: high, low, or unclocked
// (RULE_03) Enter deepest mode all peripherals still support
// (RULE_04) External clocks: application keeps range, no fallback
// (RULE_05) DMA trigger forces temporary active mode; the code does so only in modes below rtc_only_mode
// (RULE_06) Accelerator busy delays low-power entry
// (RULE_07) UART: idle unclocked, subsystem high, aux low
// (RULE_08) I2C slave unclocked awaiting start or slow
// (RULE_09) ADC: subsystem/oscillator high, aux low, idle unclocked
// (RULE_10) Interrupt wakes, then returns to same mode; the code wakes only in modes below rtc_only_mode
// (RULE_11) Deepest two modes drop core supply, reset
// (RULE_12) Re-evaluate on every peripheral change
package lpm_arbiter_pkg;

    typedef enum logic [3:0] {
        active_mode       = 4'h0,
        cpu_off_mode      = 4'h1,
        cpu_off_mode_deep = 4'h2,
        standby_mode_a    = 4'h3,
        standby_mode_b    = 4'h4,
        clocks_off_mode   = 4'h5,
        rtc_only_mode     = 4'h6,
        shutdown_mode     = 4'h7
    } pmode_t;

    // Peripheral clock demand
    typedef enum logic [1:0] {
        st_unclocked = 2'h0,
        st_low_freq  = 2'h1,
        st_high_freq = 2'h2,
        st_none      = 2'h3
    } pstate_t;

    // Clock source selection reported by a serial/ADC unit
    typedef enum logic [1:0] {
        src_subsystem = 2'h0,
        src_aux       = 2'h1,
        src_module    = 2'h2,
        src_external  = 2'h3
    } csrc_t;

    localparam int unsigned N_PERIPH       = 8;
    localparam int unsigned LOW_FREQ_MAX_HZ = 50000;
    localparam int unsigned FREQ_W          = 32;

endpackage

// File: logic/periph_classifier.sv
// Per-peripheral clock-demand classifier
module periph_classifier
    import lpm_arbiter_pkg::*;
(
    input  wire logic                   active,
    input  wire logic                   waiting,
    input  wire lpm_arbiter_pkg::csrc_t src,
    input  wire logic [lpm_arbiter_pkg::FREQ_W-1:0] ext_freq_hz,
    input  wire logic                   ext_slow_is_unclocked,
    output      lpm_arbiter_pkg::pstate_t state
);
    always_comb begin
        if (!active) begin
            state = st_none;
        end else if (waiting) begin
            state = st_unclocked;                       // [RULE_07] [RULE_08] [RULE_09]
        end else begin
            unique case (src)
                src_subsystem: state = st_high_freq;   // [RULE_07] [RULE_09]
                src_module:    state = st_high_freq;   // [RULE_09]
                src_aux:       state = st_low_freq;    // [RULE_07] [RULE_09]
                src_external: begin
                    if (ext_freq_hz > FREQ_W'(LOW_FREQ_MAX_HZ)) begin
                        state = st_high_freq;           // [RULE_02]
                    end else if (ext_slow_is_unclocked) begin
                        state = st_unclocked;           // [RULE_08]
                    end else begin
                        state = st_low_freq;            // [RULE_02]
                    end
                end
            endcase
        end
    end
endmodule

// File: sim/lpm_arbiter_asserts.sv
// Checker: mode, supply and wake relations at the arbiter ports
module lpm_arbiter_asserts
    import lpm_arbiter_pkg::*;
(
    input wire logic                    ref_clk,
    input wire logic                    rstn,
    input wire lpm_arbiter_pkg::pmode_t req_mode,
    input wire logic                    high_side_supervisor_enable,
    input wire logic                    dma_trigger,
    input wire logic                    crc_busy,
    input wire logic                    hardware_multiplier_busy,
    input wire logic                    cipher_busy,
    input wire logic                    irq_pending,
    input wire lpm_arbiter_pkg::pmode_t cur_mode,
    input wire logic                    supply_supervisor,
    input wire logic                    core_supply_on,
    input wire logic                    periph_reset,
    input wire logic                    rtc_keep_alive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_core_drop: assert property (cur_mode >= rtc_only_mode |->
        !core_supply_on && periph_reset) else $error("core kept");
    a_core_keep: assert property (cur_mode < rtc_only_mode |->
        core_supply_on && !periph_reset) else $error("core dropped");
    a_rtc_alive: assert property (
        rtc_keep_alive == (cur_mode != shutdown_mode)) else $error("rtc");
    a_sup_forced: assert property (cur_mode < standby_mode_a
        |-> supply_supervisor) else $error("supervisor off");
    a_sup_bit: assert property (cur_mode >= standby_mode_a &&
        $stable(high_side_supervisor_enable) |->
        supply_supervisor == high_side_supervisor_enable)
        else $error("supervisor bit");
    a_accel_hold: assert property ((crc_busy || cipher_busy ||
        hardware_multiplier_busy) |=> cur_mode == active_mode)
        else $error("entry not held");
    a_no_deeper: assert property (
        cur_mode <= $past(req_mode)) else $error("deeper than asked");
    a_dma_wake: assert property (dma_trigger && cur_mode != active_mode
        && cur_mode < rtc_only_mode && req_mode < rtc_only_mode
        |=> cur_mode == active_mode) else $error("no dma wake");
    a_irq_wake: assert property (irq_pending && cur_mode != active_mode
        && cur_mode < rtc_only_mode && req_mode < rtc_only_mode
        |=> cur_mode == active_mode)
        else $error("no irq wake");
    c_dma: cover property (dma_trigger && cur_mode == clocks_off_mode);
    c_irq: cover property (irq_pending && cur_mode == standby_mode_a);
    c_off: cover property (cur_mode == shutdown_mode);
endmodule

bind low_power_mode_arbiter lpm_arbiter_asserts chk (.ref_clk, .rstn,
    .req_mode, .high_side_supervisor_enable, .dma_trigger, .crc_busy,
    .hardware_multiplier_busy, .cipher_busy, .irq_pending, .cur_mode,
    .supply_supervisor, .core_supply_on, .periph_reset, .rtc_keep_alive);

// File: sim/lpm_partner.sv
// Peripheral model: one unit reports its clock use, others stay idle
module lpm_partner
    import lpm_arbiter_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic [2:0]            kind,
    output logic [N_PERIPH-1:0]        p_active,
    output logic [N_PERIPH-1:0]        p_waiting,
    output logic [N_PERIPH-1:0]        p_slow_unclocked,
    output logic [N_PERIPH*2-1:0]      p_src,
    output logic [N_PERIPH*FREQ_W-1:0] p_ext_freq
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            {p_active, p_waiting, p_slow_unclocked, p_src} <= '0;
            p_ext_freq <= '0;
        end else begin
            p_active <= {7'h00, kind != 3'h0};
            p_waiting <= {7'h00, kind == 3'h3};
            p_slow_unclocked <= {7'h00, kind == 3'h5};
            p_ext_freq <= ~p_ext_freq;
            case (kind)
                3'h2: p_src <= 16'h0001;
                3'h4, 3'h5, 3'h6: begin
                    p_src <= 16'h0003;
                    p_ext_freq[31:0] <= kind == 3'h4 ? 32'h0000_EA60
                                                     : 32'h0000_C350;
                end
                3'h7: p_src <= 16'h0002;
                default: p_src <= 16'h0000;
            endcase
        end
    end
endmodule

// File: sim/low_power_mode_arbiter_tb_top.sv
// Testbench: mode clamping, supervisor, accelerator hold and wakes
module low_power_mode_arbiter_tb_top;
    import lpm_arbiter_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    pmode_t req_mode, cur_mode;
    logic ref_clk, rstn, high_side_supervisor_enable, dma_trigger, dma_done;
    logic crc_busy, hardware_multiplier_busy, cipher_busy, irq_pending;
    logic irq_return, supply_supervisor, core_supply_on, periph_reset;
    logic rtc_keep_alive;
    logic [N_PERIPH-1:0] p_active, p_waiting, p_slow_unclocked;
    logic [N_PERIPH*2-1:0] p_src;
    logic [N_PERIPH*FREQ_W-1:0] p_ext_freq;
    logic [2:0] kind;
    logic [3:0] allow [8] = '{4'h7, 4'h2, 4'h4, 4'h5, 4'h2, 4'h5, 4'h4, 4'h2};
    int failures, checks;
    lpm_partner model (.ref_clk, .rstn, .kind, .p_active, .p_waiting,
        .p_slow_unclocked, .p_src, .p_ext_freq);
    low_power_mode_arbiter dut (.ref_clk, .rstn, .req_mode,
        .high_side_supervisor_enable, .p_active, .p_waiting, .p_src,
        .p_slow_unclocked, .p_ext_freq, .dma_trigger, .dma_done, .crc_busy,
        .hardware_multiplier_busy, .cipher_busy, .irq_pending, .irq_return,
        .cur_mode, .supply_supervisor, .core_supply_on, .periph_reset,
        .rtc_keep_alive);
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic strobe(input logic [3:0] w);
        @(posedge ref_clk);
        {dma_trigger, dma_done, irq_pending, irq_return} <= w;
        @(posedge ref_clk);
        {dma_trigger, dma_done, irq_pending, irq_return} <= 4'h0;
        tick(2);
    endtask
    task automatic t_clamp;
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            kind <= k[2:0];
            req_mode <= shutdown_mode;
            tick(4);
            cmp(cur_mode, allow[k]);
            @(posedge ref_clk);
            req_mode <= standby_mode_a;
            tick(3);
            cmp(cur_mode, allow[k] < 4'h3 ? allow[k] : 4'h3);
        end
        $display("t_clamp done");
    endtask
    task automatic t_sup;
        for (int m = 0; m < 16; m++) begin
            @(posedge ref_clk);
            kind <= 3'h0;
            req_mode <= pmode_t'({1'b0, m[2:0]});
            high_side_supervisor_enable <= m[3];
            tick(4);
            cmp({3'h0, supply_supervisor}, m[2:0] < 3 ? 4'h1 : m[3]);
            cmp({3'h0, periph_reset}, {3'h0, m[2:0] >= 3'h6});
            cmp({3'h0, core_supply_on}, {3'h0, m[2:0] < 3'h6});
            cmp({3'h0, rtc_keep_alive}, {3'h0, m[2:0] != 3'h7});
        end
        $display("t_sup done");
    endtask
    task automatic t_accel;
        for (int b = 0; b < 3; b++) begin
            @(posedge ref_clk);
            req_mode <= standby_mode_b;
            {crc_busy, hardware_multiplier_busy, cipher_busy} <= 3'h4 >> b;
            tick(3);
            cmp(cur_mode, active_mode);
            @(posedge ref_clk);
            {crc_busy, hardware_multiplier_busy, cipher_busy} <= 3'h0;
            tick(3);
            cmp(cur_mode, standby_mode_b);
        end
        $display("t_accel done");
    endtask
    task automatic t_wake;
        @(posedge ref_clk);
        req_mode <= clocks_off_mode;
        tick(3);
        strobe(4'h8);
        cmp(cur_mode, active_mode);
        strobe(4'h4);
        cmp(cur_mode, clocks_off_mode);
        strobe(4'h2);
        cmp(cur_mode, active_mode);
        strobe(4'h1);
        cmp(cur_mode, clocks_off_mode);
        $display("t_wake done");
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        stop_test;
    end
    initial begin
        {rstn, high_side_supervisor_enable, dma_trigger, dma_done} = 4'h0;
        {crc_busy, hardware_multiplier_busy, cipher_busy} = 3'h0;
        {irq_pending, irq_return, kind} = 5'h00;
        req_mode = active_mode;
        tick(5);
        cmp(cur_mode, active_mode);
        rstn <= 1'b1;
        t_clamp;
        t_sup;
        t_accel;
        t_wake;
        stop_test;
    end
endmodule
